// ==== osc_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the oscillator control block
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   Register indexes are kept; byte address is four times the index
package osc_ctrl_pkg;

    // ==========================================================
    // Register map
    localparam int          ADDR_W          = 12;
    localparam logic [7:0]  EXT_CTRL_INDEX  = 8'hb1;
    localparam logic [7:0]  LF_CTRL_INDEX   = 8'he3;
    localparam logic [11:0] EXT_CTRL_ADDR   = {2'b00, EXT_CTRL_INDEX, 2'b00};
    localparam logic [11:0] LF_CTRL_ADDR    = {2'b00, LF_CTRL_INDEX, 2'b00};

    // ==========================================================
    // Low-frequency control fields
    localparam int          LF_EN_BIT       = 7;
    localparam int          LF_RDY_BIT      = 6;
    localparam int          LF_TRIM_LSB     = 2;
    localparam int          LF_DIV_LSB      = 0;
    localparam logic [3:0]  LF_TRIM_RESET   = 4'h8;
    localparam logic [1:0]  LF_DIV_RESET    = 2'h0;
    localparam logic [1:0]  LF_DIV_8        = 2'h0;
    localparam logic [1:0]  LF_DIV_4        = 2'h1;
    localparam logic [1:0]  LF_DIV_2        = 2'h2;
    localparam logic [1:0]  LF_DIV_1        = 2'h3;
    localparam int          LF_NOMINAL_KHZ  = 80;
    localparam int          LF_SETTLE_TICKS = 16;

    // ==========================================================
    // External oscillator control fields
    localparam int          EXT_MODE_LSB    = 4;
    localparam int          EXT_FREQ_LSB    = 0;
    localparam logic [2:0]  EXT_MODE_RESET  = 3'h0;
    localparam logic [2:0]  EXT_FREQ_RESET  = 3'h0;
    localparam logic [2:0]  EXT_MODE_CMOS   = 3'h2;
    localparam logic [2:0]  EXT_MODE_CMOS_2 = 3'h3;
    localparam logic [2:0]  EXT_MODE_RC_2   = 3'h4;
    localparam logic [2:0]  EXT_MODE_CAP_2  = 3'h5;

    typedef struct packed {
        logic       enable;
        logic [3:0] trim;
        logic [1:0] div_sel;
    } lf_ctrl_type;

    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] freq_range;
    } ext_ctrl_type;

endpackage

// ==== osc_ctrl.sv ====
// Purpose: Low-frequency oscillator and external oscillator control, APB slave
// Assumes: Oscillator ticks and the external clock pin are synchronous to i_core_clk
// Notes:   Zero-wait-state reads and writes; unmapped addresses answer pslverr
//
// Functional notes
// - Low-frequency oscillator runs only while its enable bit 7 is one.
// - Read-only ready flag at bit 6 shows the oscillator has stabilised.
// - Ready clears only on reset or a write changing the divider select.
// - Trim field bits 5:2 tunes oscillator, 0000b fastest, 1111b slowest.
// - Divider field 1:0 selects divide by 8, 4, 2 or 1.
// - External drive stays off while mode field 6:4 holds 00x.
// - Mode 010 takes a CMOS clock; 011 takes it through divide by two.
// - RC and capacitor modes follow a divide by two; 11x reserved.
// - Bits 7 and 3 of the external control read zero, writes ignored.
// - Enabled external modes take their clock from the dedicated pin.
// - Undivided oscillator nominal 80 kHz, giving 80, 40, 20, 10 kHz.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module osc_ctrl #(
    parameter int SETTLE_TICKS = osc_ctrl_pkg::LF_SETTLE_TICKS
) (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rst,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [osc_ctrl_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              i_lf_osc_tick,
    input  wire logic                              i_ext_clock_pin,
    output logic                                   o_lf_osc_enable,
    output logic      [3:0]                        o_lf_osc_trim,
    output logic                                   o_lf_clk_tick,
    output logic                                   o_lf_osc_ready,
    output logic                                   o_ext_drive_en,
    output logic                                   o_ext_analog_pin,
    output logic      [2:0]                        o_ext_freq_range,
    output logic                                   o_ext_clk_tick
);

    // ==========================================================
    // State
    localparam int SW = $clog2(SETTLE_TICKS + 1);

    typedef struct packed {
        osc_ctrl_pkg::lf_ctrl_type  lf;
        osc_ctrl_pkg::ext_ctrl_type ext;
        logic                       lf_ready;
        logic [SW-1:0]              settle_cnt;
        logic [2:0]                 div_cnt;
        logic                       lf_tick;
        logic                       pin_last;
        logic                       ext_half;
        logic                       ext_tick;
        logic [31:0]                rdata;
    } state_type;

    state_type state_q;
    state_type state_d;

    logic       hit_ext;
    logic       hit_lf;
    logic       wr_en;
    logic [2:0] div_last;
    logic       div_done;
    logic       pin_rise;
    logic       ext_on;
    logic       ext_halved;
    logic [7:0] lf_read;
    logic [7:0] ext_read;

    // ==========================================================
    // Bus decode
    assign hit_ext = (paddr == osc_ctrl_pkg::EXT_CTRL_ADDR);
    assign hit_lf  = (paddr == osc_ctrl_pkg::LF_CTRL_ADDR);
    assign wr_en   = psel && penable && pwrite && (hit_ext || hit_lf);
    // Read data is captured in setup, so the access phase never waits
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !(hit_ext || hit_lf);

    assign lf_read = {state_q.lf.enable, state_q.lf_ready,
                      state_q.lf.trim, state_q.lf.div_sel};
    assign ext_read = {1'b0, state_q.ext.mode, 1'b0, state_q.ext.freq_range};

    // ==========================================================
    // Low-frequency divider
    always_comb begin
        case (state_q.lf.div_sel)
            osc_ctrl_pkg::LF_DIV_8: div_last = 3'h7;
            osc_ctrl_pkg::LF_DIV_4: div_last = 3'h3;
            osc_ctrl_pkg::LF_DIV_2: div_last = 3'h1;
            default:                div_last = 3'h0;
        endcase
    end

    // Raw ticks are counted only while the oscillator is enabled
    assign div_done = state_q.lf.enable && i_lf_osc_tick
                      && (state_q.div_cnt >= div_last);

    // ==========================================================
    // External clock path
    assign pin_rise = i_ext_clock_pin && !state_q.pin_last;
    assign ext_on   = (state_q.ext.mode == osc_ctrl_pkg::EXT_MODE_CMOS)
                   || (state_q.ext.mode == osc_ctrl_pkg::EXT_MODE_CMOS_2)
                   || (state_q.ext.mode == osc_ctrl_pkg::EXT_MODE_RC_2)
                   || (state_q.ext.mode == osc_ctrl_pkg::EXT_MODE_CAP_2);
    assign ext_halved = (state_q.ext.mode != osc_ctrl_pkg::EXT_MODE_CMOS);

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        state_d.lf_tick  = 1'b0;
        state_d.ext_tick = 1'b0;
        state_d.pin_last = i_ext_clock_pin;

        if (psel && !penable) begin
            if (hit_lf) begin
                state_d.rdata = {24'h00_0000, lf_read};
            end else if (hit_ext) begin
                state_d.rdata = {24'h00_0000, ext_read};
            end else begin
                state_d.rdata = 32'h0000_0000;
            end
        end

        if (state_q.lf.enable && i_lf_osc_tick) begin
            if (div_done) begin
                state_d.div_cnt = 3'h0;
                state_d.lf_tick = 1'b1;
            end else begin
                state_d.div_cnt = state_q.div_cnt + 3'h1;
            end
        end

        // Settling counts divided ticks; ready then holds until cleared
        if (div_done && !state_q.lf_ready) begin
            if (state_q.settle_cnt >= SW'(SETTLE_TICKS - 1)) begin
                state_d.lf_ready = 1'b1;
            end else begin
                state_d.settle_cnt = state_q.settle_cnt + SW'(1);
            end
        end

        if (ext_on && pin_rise) begin
            if (ext_halved) begin
                state_d.ext_half = !state_q.ext_half;
                state_d.ext_tick = state_q.ext_half;
            end else begin
                state_d.ext_tick = 1'b1;
            end
        end

        if (wr_en && hit_lf) begin
            state_d.lf.enable  = pwdata[osc_ctrl_pkg::LF_EN_BIT];
            state_d.lf.trim    = pwdata[osc_ctrl_pkg::LF_TRIM_LSB +: 4];
            state_d.lf.div_sel = pwdata[osc_ctrl_pkg::LF_DIV_LSB +: 2];
            // A new divide ratio restarts settling; this clear wins over a set
            if (pwdata[osc_ctrl_pkg::LF_DIV_LSB +: 2] != state_q.lf.div_sel) begin
                state_d.lf_ready   = 1'b0;
                state_d.settle_cnt = '0;
                state_d.div_cnt    = 3'h0;
                state_d.lf_tick    = 1'b0;
            end
        end

        if (wr_en && hit_ext) begin
            state_d.ext.mode       = pwdata[osc_ctrl_pkg::EXT_MODE_LSB +: 3];
            state_d.ext.freq_range = pwdata[osc_ctrl_pkg::EXT_FREQ_LSB +: 3];
            state_d.ext_half       = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q.lf.enable      <= 1'b0;
            state_q.lf.trim        <= osc_ctrl_pkg::LF_TRIM_RESET;
            state_q.lf.div_sel     <= osc_ctrl_pkg::LF_DIV_RESET;
            state_q.ext.mode       <= osc_ctrl_pkg::EXT_MODE_RESET;
            state_q.ext.freq_range <= osc_ctrl_pkg::EXT_FREQ_RESET;
            state_q.lf_ready       <= 1'b0;
            state_q.settle_cnt     <= '0;
            state_q.div_cnt        <= 3'h0;
            state_q.lf_tick        <= 1'b0;
            state_q.pin_last       <= 1'b0;
            state_q.ext_half       <= 1'b0;
            state_q.ext_tick       <= 1'b0;
            state_q.rdata          <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata           = state_q.rdata;
    assign o_lf_osc_enable  = state_q.lf.enable;
    assign o_lf_osc_trim    = state_q.lf.trim;
    assign o_lf_clk_tick    = state_q.lf_tick;
    assign o_lf_osc_ready   = state_q.lf_ready;
    assign o_ext_drive_en   = ext_on;
    assign o_ext_analog_pin = (state_q.ext.mode == osc_ctrl_pkg::EXT_MODE_RC_2)
                           || (state_q.ext.mode == osc_ctrl_pkg::EXT_MODE_CAP_2);
    assign o_ext_freq_range = state_q.ext.freq_range;
    assign o_ext_clk_tick   = state_q.ext_tick;

endmodule

// ==== osc_ctrl_assertions.sv ====
// Purpose: Port-level checks on the oscillator control block
// Assumes: One clock domain, async active-high reset
// Notes:   Bound to every osc_ctrl instance
`timescale 1ns/1ps
module osc_ctrl_assertions (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        i_lf_osc_tick,
    input wire logic        i_ext_clock_pin,
    input wire logic        o_lf_osc_enable,
    input wire logic [3:0]  o_lf_osc_trim,
    input wire logic        o_lf_clk_tick,
    input wire logic        o_lf_osc_ready,
    input wire logic        o_ext_drive_en,
    input wire logic        o_ext_analog_pin,
    input wire logic [2:0]  o_ext_freq_range,
    input wire logic        o_ext_clk_tick
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic lf_wr;
    assign lf_wr = psel && penable && pwrite && paddr == osc_ctrl_pkg::LF_CTRL_ADDR;
    // ==========
    // Read accesses; data was captured at the setup edge, hence $past
    sequence s_lf_rd;
        psel && penable && !pwrite && paddr == osc_ctrl_pkg::LF_CTRL_ADDR;
    endsequence
    sequence s_ext_rd;
        psel && penable && !pwrite && paddr == osc_ctrl_pkg::EXT_CTRL_ADDR;
    endsequence
    a_lf_read_fields: assert property (s_lf_rd |-> prdata[31:2] ==
        {24'h00_0000, $past(o_lf_osc_enable), $past(o_lf_osc_ready), $past(o_lf_osc_trim)})
        else $error("low-frequency read fields wrong");
    a_ext_read_zero: assert property (s_ext_rd |-> prdata[31:7] == 25'h0 &&
        !prdata[3] && prdata[2:0] == o_ext_freq_range &&
        o_ext_drive_en == (prdata[6:5] == 2'h1 || prdata[6:5] == 2'h2))
        else $error("external read fields wrong");
    a_lf_tick_off: assert property (!o_lf_osc_enable && !$past(o_lf_osc_enable)
        |-> !o_lf_clk_tick) else $error("divided tick while disabled");
    a_lf_tick_cause: assert property (o_lf_clk_tick |-> $past(i_lf_osc_tick))
        else $error("divided tick without raw tick");
    a_ready_sticky: assert property (o_lf_osc_ready && !lf_wr |=> o_lf_osc_ready)
        else $error("ready dropped without divider write");
    a_ready_rise: assert property ($rose(o_lf_osc_ready) |->
        o_lf_clk_tick || $past(o_lf_clk_tick)) else $error("ready rose without tick");
    a_ext_tick_off: assert property (!o_ext_drive_en && !$past(o_ext_drive_en)
        |-> !o_ext_clk_tick) else $error("external tick while off");
    a_ext_tick_edge: assert property (o_ext_clk_tick |->
        $past(i_ext_clock_pin) && !$past(i_ext_clock_pin, 2))
        else $error("external tick without pin edge");
    a_analog_drive: assert property (o_ext_analog_pin |-> o_ext_drive_en)
        else $error("analog pin outside RC or capacitor mode");
endmodule
bind osc_ctrl osc_ctrl_assertions osc_ctrl_assertions_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .i_lf_osc_tick(i_lf_osc_tick),
    .i_ext_clock_pin(i_ext_clock_pin), .o_lf_osc_enable(o_lf_osc_enable),
    .o_lf_osc_trim(o_lf_osc_trim), .o_lf_clk_tick(o_lf_clk_tick),
    .o_lf_osc_ready(o_lf_osc_ready), .o_ext_drive_en(o_ext_drive_en),
    .o_ext_analog_pin(o_ext_analog_pin), .o_ext_freq_range(o_ext_freq_range),
    .o_ext_clk_tick(o_ext_clk_tick));

// ==== ext_clk_src.sv ====
// Purpose: External clock source wired to the dedicated clock pin
// Assumes: Pin level is synchronous to the core clock
// Notes:   Parked low while stopped, like a gated CMOS clock
// Pin is reserved for the oscillator and set up as its input
`timescale 1ns/1ps
module ext_clk_src #(
    parameter int HALF = 3
) (
    input  wire logic i_core_clk,
    input  wire logic i_run,
    output logic      o_pin
);
    int cnt;
    always @(posedge i_core_clk) begin
        if (!i_run) begin
            cnt <= 0;
            o_pin <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            o_pin <= !o_pin;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ==== osc_ctrl_tb.sv ====
// Purpose: Self-checking bench for osc_ctrl
// Assumes: Settling count shortened to 2 divided ticks
// Notes:   Reads are scored by a monitor against a queue of notes
`timescale 1ns/1ps
module osc_ctrl_tb;
    localparam logic [11:0] LF  = osc_ctrl_pkg::LF_CTRL_ADDR;
    localparam logic [11:0] EXT = osc_ctrl_pkg::EXT_CTRL_ADDR;
    logic        i_core_clk, i_rst, psel, penable, pwrite, i_lf_osc_tick, run, ext_pin;
    logic        pready, pslverr, lf_en, lf_tick, lf_rdy, drv_en, ana, ext_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  trim, t;
    logic [2:0]  frange, f;
    logic [32:0] expq[$];
    int          error_cnt, checks, lf_cnt, ext_cnt;
    osc_ctrl #(.SETTLE_TICKS(2)) osc_ctrl_inst (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_lf_osc_tick(i_lf_osc_tick), .i_ext_clock_pin(ext_pin),
        .o_lf_osc_enable(lf_en), .o_lf_osc_trim(trim), .o_lf_clk_tick(lf_tick),
        .o_lf_osc_ready(lf_rdy), .o_ext_drive_en(drv_en), .o_ext_analog_pin(ana),
        .o_ext_freq_range(frange), .o_ext_clk_tick(ext_tick));
    ext_clk_src #(.HALF(3)) ext_clk_src_inst (.i_core_clk(i_core_clk), .i_run(run),
        .o_pin(ext_pin));
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    // ==========
    // Shared tasks
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge i_core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) expq.push_back(e);
        @(posedge i_core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave's answer
        do begin
            @(posedge i_core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse_lf(input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            i_lf_osc_tick <= 1'b1;
        end
        @(posedge i_core_clk);
        i_lf_osc_tick <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========
    // Monitor and tick counters
    always @(posedge i_core_clk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            chk({pslverr, prdata}, expq.pop_front());
        end
        if (lf_tick === 1'b1) lf_cnt++;
        if (ext_tick === 1'b1) ext_cnt++;
    end
    initial begin
        #1_000_000;
        error_cnt++;
        results();
    end
    initial begin
        {i_rst, psel, penable, pwrite, i_lf_osc_tick, run} = 6'h20;
        {paddr, pwdata, error_cnt, checks, lf_cnt, ext_cnt} = '0;
        void'($urandom(59581));
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        apb(1'b0, EXT, 32'h0, 33'h0);
        apb(1'b0, LF, 32'h0, {27'h0, osc_ctrl_pkg::LF_TRIM_RESET, 2'h0});
        apb(1'b0, 12'h004, 32'h0, {1'b1, 32'h0});
        $display("test reset values done");
        for (int m = 0; m < 8; m++) begin
            f = 3'($urandom);
            apb(1'b1, EXT, {24'h00_0000, 1'b1, 3'(m), 1'b1, f}, 33'h0);
            apb(1'b0, EXT, 32'h0, {26'h000_0000, 3'(m), 1'b0, f});
            chk(33'({drv_en, ana, frange}), 33'({m > 1 && m < 6, m > 3 && m < 6, f}));
            ext_cnt = 0;
            run <= 1'b1;
            repeat (24) @(posedge i_core_clk);
            run <= 1'b0;
            repeat (4) @(posedge i_core_clk);
            chk(33'(ext_cnt), m == 2 ? 33'h4 : (m > 2 && m < 6) ? 33'h2 : 33'h0);
        end
        $display("test external modes done");
        for (int d = 0; d < 4; d++) begin
            t = 4'($urandom);
            apb(1'b1, LF, {24'h00_0000, 2'h2, t, 2'(d)}, 33'h0);
            apb(1'b0, LF, 32'h0, {25'h0, 2'h2, t, 2'(d)});
            chk(33'({lf_en, trim}), 33'({1'b1, t}));
            lf_cnt = 0;
            pulse_lf(16);
            chk(33'(lf_cnt), 33'(16 >> (3 - d)));
            apb(1'b0, LF, 32'h0, {25'h0, 2'h3, t, 2'(d)});
        end
        apb(1'b1, LF, {24'h00_0000, 2'h0, t, 2'h3}, 33'h0);
        lf_cnt = 0;
        pulse_lf(8);
        chk(33'(lf_cnt), 33'h0);
        apb(1'b0, LF, 32'h0, {25'h0, 2'h1, t, 2'h3});
        apb(1'b1, LF, {24'h00_0000, 2'h0, t, 2'h2}, 33'h0);
        apb(1'b0, LF, 32'h0, {25'h0, 2'h0, t, 2'h2});
        $display("test low-frequency divider done");
        results();
    end
endmodule
